// file: design/pcs_pkg.sv
// Purpose: Shared constants for the program counter and return stack.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Widths follow the documented 13-bit counter and 2K-word memory.
package pcs_pkg;

  localparam int          PC_W       = 13;  // Full program counter width.
  localparam int          IMPL_W     = 11;  // Implemented program space, 2K words.
  localparam int          LOW_W      = 8;   // Software-visible low byte.
  localparam int          HI_W       = 5;   // Hidden high part, bits 12 to 8.
  localparam int          TGT_W      = 11;  // Target field of call and jump.
  localparam int          STK_DEPTH  = 8;   // Return stack entries.
  localparam int          STK_PTR_W  = 3;   // Stack pointer width.
  localparam int          PAGE_BIT   = 3;   // Page-select bit of the latch.
  localparam int          PAGE_HI    = 4;   // Top latch bit feeding bit 12.
  localparam logic [PC_W-1:0]      RESET_VEC  = 13'h0000;
  localparam logic [PC_W-1:0]      IRQ_VEC    = 13'h0004;
  localparam logic [PC_W-1:0]      PC_STEP    = 13'h0001;
  localparam logic [HI_W-1:0]      LATCH_RST  = 5'h00;
  localparam logic [STK_PTR_W-1:0] PTR_RST    = 3'h0;
  localparam logic [STK_PTR_W-1:0] PTR_STEP   = 3'h1;
  localparam logic [STK_PTR_W-1:0] PTR_LAST   = 3'h7;
  localparam logic [IMPL_W-1:0]    IMPL_TOP   = 11'h7ff;
  localparam logic [IMPL_W-1:0]    IMPL_BASE  = 11'h000;

endpackage : pcs_pkg

// file: design/pcs_stk_if.sv
// Purpose: Carrier between the sequencer and its return stack.
// Assumes: Push and pop are never requested together.
// Notes:   The top entry is always presented on top_data.
`timescale 1ns/1ps
interface pcs_stk_if;
  import pcs_pkg::*;

  logic            en;         // Clock enable.
  logic            push;       // Store push_data as new top.
  logic            pop;        // Discard current top.
  logic [PC_W-1:0] push_data;  // Address to save.
  logic [PC_W-1:0] top_data;   // Most recently pushed address.

  modport ctl (output en, push, pop, push_data, input top_data);
  modport stk (input en, push, pop, push_data, output top_data);

endinterface : pcs_stk_if

// file: design/pcs_stack.sv
// Purpose: Eight-entry circular return stack.
// Assumes: Pointer is private; nothing outside can read or set it.
// Notes:   A ninth push overwrites the oldest entry with no warning.
`timescale 1ns/1ps
module pcs_stack (
  input  wire logic clk_i,    // System clock.
  input  wire logic rst_n_i,  // Synchronous reset, active low.
  pcs_stk_if.stk    stk       // Push and pop requests.
);
  import pcs_pkg::*;

  logic [PC_W-1:0]      mem_q [STK_DEPTH];
  logic [STK_PTR_W-1:0] ptr_q;
  logic [STK_PTR_W-1:0] top_idx;

  assign top_idx      = ptr_q - PTR_STEP;
  assign stk.top_data = mem_q[top_idx];

  // ---------------------------------------------------------------
  // Pointer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ptr_q <= PTR_RST;
    end else if (stk.en && stk.push) begin
      ptr_q <= ptr_q + PTR_STEP;
    end else if (stk.en && stk.pop) begin
      ptr_q <= top_idx;
    end
  end

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (stk.en && stk.push) begin
      mem_q[ptr_q] <= stk.push_data;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  ptr_wrap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    stk.en && stk.push && ptr_q == PTR_LAST |=> ptr_q == PTR_RST)
    else $error("Stack pointer did not wrap after eighth entry.");

  push_pop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    stk.en && stk.push ##1 stk.en && stk.pop && !stk.push |=>
      ptr_q == $past(ptr_q, 2))
    else $error("Push followed by pop did not restore the pointer.");

endmodule : pcs_stack

// file: design/pcs_top.sv
// Purpose: Program counter, high-address latch and return stack sequencing.
// Assumes: Decoder and interrupt logic share clk_i and give one-cycle commands.
// Notes:   Priority is interrupt, call, jump, return, low-byte write, step.
`timescale 1ns/1ps

// Contract
// - Keep a 13-bit program counter.
// - Fetch addresses wrap within 2K words.
// - Reset to zero; interrupt jumps to four.
// - Low counter byte readable and writable.
// - High bits change only via latch; returns, interrupts, calls, jumps and step carries also move them.
// - Private eight-entry stack, hidden pointer.
// - Call or interrupt pushes the counter.
// - Any return pops into the counter. A return beside an interrupt, call or jump does not pop.
// - Push and pop leave latch alone.
// - Stack is circular, silent overwrite.
// - Call and jump carry 11 target bits.
// - Page bit comes from latch bit three.
// - Returns restore all 13 bits.
module pcs_top (
  input  wire logic                       clk_i,          // System clock.
  input  wire logic                       rst_n_i,        // Sync reset, active low.
  input  wire logic                       ce_i,           // Clock enable.
  input  wire logic                       step_i,         // Advance to next word.
  input  wire logic                       irq_i,          // Take interrupt.
  input  wire logic                       call_i,         // Call instruction.
  input  wire logic                       jump_instr_i,   // Jump instruction.
  input  wire logic [pcs_pkg::TGT_W-1:0]  target_i,       // Call or jump target.
  input  wire logic                       ret_i,          // Any return kind.
  input  wire logic                       pc_low_byte_wr_i,    // Write low byte.
  input  wire logic [pcs_pkg::LOW_W-1:0]  pc_low_byte_wdata_i, // Low byte data.
  input  wire logic                       latch_wr_i,     // Write high latch.
  input  wire logic [pcs_pkg::HI_W-1:0]   latch_wdata_i,  // High latch data.
  output logic      [pcs_pkg::IMPL_W-1:0] fetch_addr_o,   // Wrapped fetch address.
  output logic      [pcs_pkg::PC_W-1:0]   pc_o,           // Full counter.
  output logic      [pcs_pkg::LOW_W-1:0]  pc_low_byte_o,  // Low byte read.
  output logic      [pcs_pkg::HI_W-1:0]   pc_high_latch_o // Latch read.
);
  import pcs_pkg::*;

  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] pc_d;
  logic [HI_W-1:0] pc_high_latch_q;
  logic [PC_W-1:0] branch_tgt;

  pcs_stk_if stk_if ();

  pcs_stack u_stack (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .stk     (stk_if.stk)
  );

  // ---------------------------------------------------------------
  // Stack requests
  // ---------------------------------------------------------------
  // The counter already names the next word, so it is the return address.
  assign stk_if.en        = ce_i;
  assign stk_if.push      = irq_i || call_i;
  assign stk_if.pop       = ret_i && !irq_i && !call_i && !jump_instr_i;
  assign stk_if.push_data = pc_q;

  // Upper two bits come from the latch; bit 11 is the page-select bit.
  assign branch_tgt = {pc_high_latch_q[PAGE_HI], pc_high_latch_q[PAGE_BIT],
                       target_i};

  // ---------------------------------------------------------------
  // Next counter value
  // ---------------------------------------------------------------
  always_comb begin
    pc_d = pc_q;
    if (irq_i) begin
      pc_d = IRQ_VEC;
    end else if (call_i || jump_instr_i) begin
      pc_d = branch_tgt;
    end else if (ret_i) begin
      pc_d = stk_if.top_data;
    end else if (pc_low_byte_wr_i) begin
      pc_d = {pc_high_latch_q, pc_low_byte_wdata_i};
    end else if (step_i) begin
      pc_d = pc_q + PC_STEP;
    end
  end

  // ---------------------------------------------------------------
  // Program counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pc_q <= RESET_VEC;
    end else if (ce_i) begin
      pc_q <= pc_d;
    end
  end

  // ---------------------------------------------------------------
  // High-address latch
  // ---------------------------------------------------------------
  // Only a direct write changes it; stack traffic never does.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pc_high_latch_q <= LATCH_RST;
    end else if (ce_i && latch_wr_i) begin
      pc_high_latch_q <= latch_wdata_i;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign fetch_addr_o    = pc_q[IMPL_W-1:0];
  assign pc_o            = pc_q;
  assign pc_low_byte_o   = pc_q[LOW_W-1:0];
  assign pc_high_latch_o = pc_high_latch_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  logic only_step;
  assign only_step = ce_i && step_i && !irq_i && !call_i && !jump_instr_i && !ret_i
                     && !pc_low_byte_wr_i;

  reset_vector_a: assert property (disable iff (1'b0)
    !rst_n_i |=> pc_o == RESET_VEC && fetch_addr_o == IMPL_BASE)
    else $error("Counter not at reset vector after reset.");

  irq_vector_a: assert property (
    ce_i && irq_i |=> pc_o == IRQ_VEC)
    else $error("Interrupt did not branch to vector four.");

  irq_push_a: assert property (
    ce_i && irq_i |=> stk_if.top_data == $past(pc_q))
    else $error("Interrupt did not save the counter.");

  call_target_a: assert property (
    ce_i && (call_i || jump_instr_i) && !irq_i |=>
      pc_o[PC_W-1] == $past(pc_high_latch_q[PAGE_HI]) &&
      pc_o[TGT_W] == $past(pc_high_latch_q[PAGE_BIT]) &&
      pc_o[TGT_W-1:0] == $past(target_i))
    else $error("Branch target or page bit wrong.");

  call_return_a: assert property (
    ce_i && call_i && !irq_i ##1 ce_i && ret_i && !irq_i && !call_i && !jump_instr_i
      |=> pc_o == $past(pc_q, 2))
    else $error("Return did not restore full counter.");

  latch_hold_a: assert property (
    ce_i && (stk_if.push || stk_if.pop) && !latch_wr_i |=> $stable(pc_high_latch_o))
    else $error("Stack traffic changed the high latch.");

  low_write_a: assert property (
    ce_i && pc_low_byte_wr_i && !irq_i && !call_i && !jump_instr_i && !ret_i |=>
      pc_o == {$past(pc_high_latch_q), $past(pc_low_byte_wdata_i)})
    else $error("Low-byte write did not load high bits from latch.");

  fetch_wrap_a: assert property (
    only_step && pc_q[IMPL_W-1:0] == IMPL_TOP |=> fetch_addr_o == IMPL_BASE)
    else $error("Fetch address did not wrap at top of memory.");

  freeze_a: assert property (
    !ce_i |=> $stable(pc_o) && $stable(pc_high_latch_o))
    else $error("State moved while clock enable was low.");

  // ---------------------------------------------------------------
  // Checks on stepping and the stack
  // ---------------------------------------------------------------
  // A step carries out of bit 10 into the hidden high bits, so the
  // full counter moves on while only the fetch address wraps.
  step_inc_a: assert property (
    only_step |=> pc_o == $past(pc_q) + PC_STEP)
    else $error("Step did not advance the counter by one.");

  idle_hold_a: assert property (
    ce_i && !step_i && !irq_i && !call_i && !jump_instr_i && !ret_i && !pc_low_byte_wr_i
      |=> $stable(pc_o))
    else $error("Counter moved without a command.");

  call_push_a: assert property (
    ce_i && call_i && !irq_i |=> stk_if.top_data == $past(pc_q))
    else $error("Call did not save the counter.");

  // A jump that arrives beside a return must leave the stack untouched.
  jump_hold_a: assert property (
    ce_i && jump_instr_i && !irq_i && !call_i |=> $stable(stk_if.top_data))
    else $error("Jump disturbed the return stack.");

  ret_pop_a: assert property (
    ce_i && ret_i && !irq_i && !call_i && !jump_instr_i |=>
      pc_o == $past(stk_if.top_data))
    else $error("Return did not load the top stack entry.");

  // An interrupt return must bring back all 13 bits, page bits included.
  irq_return_a: assert property (
    ce_i && irq_i ##1 ce_i && ret_i && !irq_i && !call_i && !jump_instr_i
      |=> pc_o == $past(pc_q, 2))
    else $error("Return from interrupt did not restore full counter.");

  // ---------------------------------------------------------------
  // Checks on the high-address latch
  // ---------------------------------------------------------------
  latch_write_a: assert property (
    ce_i && latch_wr_i |=> pc_high_latch_o == $past(latch_wdata_i))
    else $error("Latch write did not land.");

  // Only a branch, a return, a low-byte write or a carry may move bits 12 to 8.
  high_hold_a: assert property (
    ce_i && !irq_i && !call_i && !jump_instr_i && !ret_i && !pc_low_byte_wr_i
      && !(&pc_q[LOW_W-1:0]) |=> pc_o[PC_W-1:LOW_W] == $past(pc_q[PC_W-1:LOW_W]))
    else $error("Hidden high bits changed without the latch.");

  // ---------------------------------------------------------------
  // Coverage
  // ---------------------------------------------------------------

  irq_cov_c:  cover property (ce_i && irq_i ##1 ce_i && ret_i && !irq_i);
  call_cov_c: cover property (ce_i && call_i && !irq_i ##[1:20] ce_i && ret_i);
  wrap_cov_c: cover property (only_step && pc_q[IMPL_W-1:0] == IMPL_TOP);
  lbw_cov_c:  cover property (ce_i && latch_wr_i ##1 ce_i && pc_low_byte_wr_i);
  jump_cov_c: cover property (ce_i && jump_instr_i && !irq_i && !call_i);

endmodule : pcs_top

// file: bench/pcs_dec_model.sv
// Purpose: Stand-in for the decoder and interrupt logic driving the sequencer.
// Assumes: op_i and arg_i change just after a rising edge.
// Notes:   The target bus is not held when no branch is issued.
`timescale 1ns/1ps
module pcs_dec_model (
  input  wire logic [2:0]  op_i,      // Command code from the bench.
  input  wire logic [10:0] arg_i,     // Operand.
  input  wire logic        irq_i,     // Interrupt request.
  output logic             step_o,    // Step command.
  output logic             irq_o,     // Interrupt command.
  output logic             call_o,    // Call command.
  output logic             jump_o,    // Jump command.
  output logic             ret_o,     // Return command.
  output logic             lb_wr_o,   // Low byte write.
  output logic             lat_wr_o,  // Latch write.
  output logic [10:0]      tgt_o,     // Branch target.
  output logic [7:0]       lb_o,      // Low byte data.
  output logic [4:0]       lat_o      // Latch data.
);
  assign step_o   = (op_i == 3'h1);
  assign jump_o   = (op_i == 3'h2);
  assign call_o   = (op_i == 3'h3);
  assign ret_o    = (op_i == 3'h4);
  assign lb_wr_o  = (op_i == 3'h5);
  assign lat_wr_o = (op_i == 3'h6);
  assign irq_o    = irq_i | (op_i == 3'h7);
  // An idle target bus shows the inverse, so a stale value cannot pass.
  assign tgt_o    = (call_o | jump_o) ? arg_i : ~arg_i;
  assign lb_o     = arg_i[7:0];
  assign lat_o    = arg_i[4:0];
endmodule : pcs_dec_model

// file: bench/tb_top.sv
// Purpose: Self-checking bench for the program counter and return stack.
// Assumes: Commands are spaced by one idle cycle, except in the back-to-back call, return and interrupt run.
// Notes:   Expected values are worked out by hand from the counter rules.
`timescale 1ns/1ps
module tb_top;
  import pcs_pkg::*;
  typedef struct packed {
    logic [2:0]      op;
    logic [10:0]     arg;
    logic [PC_W-1:0] pc;
    logic [HI_W-1:0] lat;
  } pcs_row_s;
  localparam pcs_row_s ROWS [13] = '{
    '{3'h1, 11'h000, 13'h0001, 5'h00}, '{3'h1, 11'h000, 13'h0002, 5'h00},
    '{3'h6, 11'h008, 13'h0002, 5'h08}, '{3'h2, 11'h123, 13'h0923, 5'h08},
    '{3'h3, 11'h7ff, 13'h0fff, 5'h08}, '{3'h1, 11'h000, 13'h1000, 5'h08},
    '{3'h7, 11'h000, 13'h0004, 5'h08}, '{3'h6, 11'h000, 13'h0004, 5'h00},
    '{3'h4, 11'h000, 13'h1000, 5'h00}, '{3'h4, 11'h000, 13'h0923, 5'h00},
    '{3'h5, 11'h05a, 13'h005a, 5'h00}, '{3'h6, 11'h01f, 13'h005a, 5'h1f},
    '{3'h5, 11'h0a5, 13'h1fa5, 5'h1f}};
  logic              clk_i, rst_n_i, ce_i, irq_q;
  logic [2:0]        op_q;
  logic [10:0]       arg_q, tgt;
  logic              step, irq, call, jump, ret, lb_wr, lat_wr;
  logic [7:0]        lb_d;
  logic [4:0]        lat_d;
  logic [IMPL_W-1:0] fetch;
  logic [PC_W-1:0]   pc;
  logic [LOW_W-1:0]  low;
  logic [HI_W-1:0]   lat;
  int                error_cnt, checked;
  pcs_dec_model dec_u (.op_i(op_q), .arg_i(arg_q), .irq_i(irq_q), .step_o(step), .irq_o(irq),
    .call_o(call), .jump_o(jump), .ret_o(ret), .lb_wr_o(lb_wr), .lat_wr_o(lat_wr),
    .tgt_o(tgt), .lb_o(lb_d), .lat_o(lat_d));
  pcs_top dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .step_i(step), .irq_i(irq),
    .call_i(call), .jump_instr_i(jump), .target_i(tgt), .ret_i(ret), .pc_low_byte_wr_i(lb_wr),
    .pc_low_byte_wdata_i(lb_d), .latch_wr_i(lat_wr), .latch_wdata_i(lat_d),
    .fetch_addr_o(fetch), .pc_o(pc), .pc_low_byte_o(low), .pc_high_latch_o(lat));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [PC_W-1:0] e, input logic [PC_W-1:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cmd(input logic [2:0] op, input logic [10:0] arg);
    @(posedge clk_i);
    op_q  <= op;
    arg_q <= arg;
    @(posedge clk_i);
    op_q  <= 3'h0;
    irq_q <= 1'b0;
    #1;
  endtask : cmd
  task automatic report_and_stop;
    if (error_cnt == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    rst_n_i = 1'b0; ce_i = 1'b1; irq_q = 1'b0; op_q = 3'h0; arg_q = 11'h000;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk("reset pc", RESET_VEC, pc);
    chk("reset latch", 13'(LATCH_RST), 13'(lat));
    foreach (ROWS[i]) begin
      cmd(ROWS[i].op, ROWS[i].arg);
      chk("pc", ROWS[i].pc, pc);
      chk("fetch", 13'(ROWS[i].pc[10:0]), 13'(fetch));
      chk("low byte", 13'(ROWS[i].pc[7:0]), 13'(low));
      chk("latch", 13'(ROWS[i].lat), 13'(lat));
    end
    // Interrupt beside a call wins and still pushes the counter.
    @(posedge clk_i);
    irq_q <= 1'b1;
    op_q  <= 3'h3;
    arg_q <= 11'h300;
    @(posedge clk_i);
    op_q  <= 3'h0;
    irq_q <= 1'b0;
    #1;
    chk("irq pc", IRQ_VEC, pc);
    cmd(3'h4, 11'h000);
    chk("irq ret", 13'h1fa5, pc);
    // Back-to-back call and return, then interrupt and return.
    @(posedge clk_i);
    op_q  <= 3'h3;
    arg_q <= 11'h040;
    @(posedge clk_i);
    op_q  <= 3'h4;
    @(posedge clk_i);
    op_q  <= 3'h7;
    @(posedge clk_i);
    op_q  <= 3'h4;
    @(posedge clk_i);
    op_q  <= 3'h0;
    #1;
    chk("back to back", 13'h1fa5, pc);
    @(posedge clk_i);
    ce_i <= 1'b0;
    cmd(3'h1, 11'h000);
    chk("frozen", 13'h1fa5, pc);
    ce_i <= 1'b1;
    cmd(3'h6, 11'h000);
    for (int i = 0; i < 10; i++) cmd(3'h3, 11'(i * 16 + 1));
    chk("latch after push", 13'h0000, 13'(lat));
    for (int k = 0; k < 8; k++) begin
      cmd(3'h4, 11'h000);
      chk("pop", 13'((8 - k) * 16 + 1), pc);
    end
    chk("latch after pop", 13'h0000, 13'(lat));
    cmd(3'h6, 11'h015);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk("rerun pc", RESET_VEC, pc);
    chk("rerun latch", 13'(LATCH_RST), 13'(lat));
    cmd(3'h1, 11'h000);
    chk("rerun step", 13'h0001, pc);
    report_and_stop();
  end
endmodule : tb_top
